// ===== rsf_config_bank.sv
// APB register bank with start-up timeout sequencer, power table and charge-pump calibration
// Summary of operation
// RQ1: Timeout field codes 0..3 wait 1, 16, 64, 256 counter expiries; resets to 01.
// RQ2: Oscillator-settled flag and active-low chip-ready change in the same cycle.
// RQ3: Keep-on bit 0 holds the oscillator running during sleep; resets to 0.
// RQ4: Three-bit power index selects a two-entry power table; resets to 000.
// RQ5: Host sets power index 001 for on-off keying, 000 otherwise.
// RQ6: Pump calibration stage skipped when enable field bits 5:4 is zero; resets 10.
// RQ7: Low four calibration bits hold pump result, host-writable; resets to 1001.
// RQ8: Host writes recommended value to calibration bits 7:6 first; resets 10.
// RQ9: Tuning register bit 2 reads zero; 7:3 reset 11111, 1:0 reset 00.
// RQ10: Six-bit counter runs after oscillator settles; ready only after all expiries.
// RQ11: Unused bits read zero, ignore writes; fields hold until rewritten or reset.
`include "rsf_regs_map.svh"
module rsf_config_bank (
    input wire logic core_clk, // 10 MHz clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [9:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic sleepReq, // Radio in sleep state
    input wire logic oscGood, // Oscillator has settled
    input wire logic calStart, // Start synthesizer calibration, pulse
    input wire logic [3:0] pumpCalCode, // Measured pump current code
    output logic oscRunEn, // Run crystal oscillator
    output logic osc_settled_flag, // Oscillator stable indication
    output logic chip_ready_n, // Chip ready, active low
    output logic calBusy, // Calibration in progress
    output rsf_pkg::rsf_drive_t drive // Power, LO buffer and pump settings
);
    // ==========================================================
    // Registers
    logic [7:0] smCfg0_ff;
    logic [7:0] resTune_ff;
    logic [7:0] frontEnd_ff;
    logic [7:0] synCal3_ff;
    logic [7:0] pwrTable_ff [`RSF_TABLE_DEPTH];
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    rsf_pkg::rsf_start_t start_ff;
    rsf_pkg::rsf_start_t nxt_start;
    rsf_pkg::rsf_cal_t cal_ff;
    rsf_pkg::rsf_cal_t nxt_cal;
    logic [5:0] ripple_ff;
    logic [8:0] expCnt_ff;
    logic [7:0] calCnt_ff;
    logic oscRunEn_ff;
    logic settled_ff;
    logic readyN_ff;
    logic calBusy_ff;
    rsf_pkg::rsf_drive_t drive_ff;

    // ==========================================================
    // Bus decode; no wait state, so the setup cycle prepares the answer
    wire setupPhase = psel & ~penable;
    wire accessDone = psel & penable & pready_ff;
    wire wrEn = accessDone & pwrite;
    wire selSm = paddr == {`RSF_IDX_SMCFG0, 2'b00};
    wire selRes = paddr == {`RSF_IDX_RESTUNE, 2'b00};
    wire selFe = paddr == {`RSF_IDX_FRONTEND, 2'b00};
    wire selCal = paddr == {`RSF_IDX_SYNCAL3, 2'b00};
    wire selTab = paddr == {`RSF_IDX_PWRTABLE, 2'b00};
    wire mapped = selSm | selRes | selFe | selCal | selTab;
    wire [7:0] wrByte = pwdata[7:0];
    wire [31:0] rdMux = selSm ? {24'h000000, smCfg0_ff} :
                        selRes ? {24'h000000, resTune_ff} :
                        selFe ? {24'h000000, frontEnd_ff} :
                        selCal ? {24'h000000, synCal3_ff} :
                        selTab ? {16'h0000, pwrTable_ff[1], pwrTable_ff[0]} : 32'h00000000;

    // Bus answer registers
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= setupPhase;
            pslverr_ff <= setupPhase & ~mapped;
            prdata_ff <= setupPhase ? rdMux : 32'h00000000;
        end
    end

    // ==========================================================
    // Configuration fields; masks keep unused bits at zero
    wire [1:0] expSel = smCfg0_ff[`RSF_EXPSEL_MSB:`RSF_EXPSEL_LSB];
    wire keepOn = smCfg0_ff[`RSF_KEEPON_BIT];
    wire [2:0] pwrIdx = frontEnd_ff[`RSF_PWRIDX_MSB:`RSF_PWRIDX_LSB];
    wire [1:0] pumpEn = synCal3_ff[`RSF_PCEN_MSB:`RSF_PCEN_LSB];
    wire pumpEnd = (cal_ff == rsf_pkg::CAL_PUMP) && (calCnt_ff == `RSF_PUMP_CAL_CYCLES);

    // Writable configuration bytes
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            smCfg0_ff <= `RSF_RST_SMCFG0; // [RQ1] [RQ3]
            resTune_ff <= `RSF_RST_RESTUNE; // [RQ9]
            frontEnd_ff <= `RSF_RST_FRONTEND; // [RQ4]
            synCal3_ff <= `RSF_RST_SYNCAL3; // [RQ6] [RQ7] [RQ8]
        end else begin
            if (wrEn && selSm) smCfg0_ff <= wrByte & `RSF_MASK_SMCFG0; // [RQ11]
            if (wrEn && selRes) resTune_ff <= wrByte & `RSF_MASK_RESTUNE; // [RQ9]
            if (wrEn && selFe) frontEnd_ff <= wrByte & `RSF_MASK_FRONTEND; // [RQ11]
            if (wrEn && selCal) synCal3_ff <= wrByte & `RSF_MASK_SYNCAL3;
            // Measured result beats a host write in the same cycle
            if (pumpEnd) synCal3_ff[`RSF_PCRES_MSB:`RSF_PCRES_LSB] <= pumpCalCode; // [RQ7]
        end
    end

    // Power table entries, one byte lane each
    for (genvar e = 0; e < `RSF_TABLE_DEPTH; e++) begin : gTable
        always_ff @(posedge core_clk) begin
            if (!rstn) begin
                pwrTable_ff[e] <= (e == 0) ? `RSF_RST_PWRENTRY0 : `RSF_RST_PWRENTRY1;
            end else if (wrEn && selTab) begin
                pwrTable_ff[e] <= pwdata[8*e +: 8];
            end
        end
    end

    // ==========================================================
    // Start-up sequencer
    wire [8:0] expTarget = (expSel == 2'b00) ? `RSF_EXPIRE_0 :
                           (expSel == 2'b01) ? `RSF_EXPIRE_1 :
                           (expSel == 2'b10) ? `RSF_EXPIRE_2 : `RSF_EXPIRE_3; // [RQ1]
    wire oscOn = oscRunEn_ff & oscGood;
    wire rippleWrap = ripple_ff == `RSF_RIPPLE_LAST;
    wire lastExpiry = rippleWrap && (expCnt_ff + 9'h001 >= expTarget); // [RQ10]

    // Next state; losing the oscillator always restarts the count
    always_comb begin
        nxt_start = start_ff;
        unique case (start_ff)
            rsf_pkg::ST_OFF: if (oscOn) nxt_start = rsf_pkg::ST_COUNT;
            rsf_pkg::ST_COUNT: begin
                if (!oscOn) nxt_start = rsf_pkg::ST_OFF;
                else if (lastExpiry) nxt_start = rsf_pkg::ST_READY; // [RQ10]
            end
            rsf_pkg::ST_READY: if (!oscOn) nxt_start = rsf_pkg::ST_OFF;
        endcase
    end

    // Counters and start-up outputs
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            start_ff <= rsf_pkg::ST_OFF;
            ripple_ff <= 6'h00;
            expCnt_ff <= 9'h000;
            oscRunEn_ff <= 1'b0;
            settled_ff <= 1'b0;
            readyN_ff <= 1'b1;
        end else begin
            start_ff <= nxt_start;
            ripple_ff <= (start_ff == rsf_pkg::ST_COUNT) ? ripple_ff + 6'h01 : 6'h00; // [RQ10]
            if (start_ff == rsf_pkg::ST_OFF) expCnt_ff <= 9'h000;
            else if (start_ff == rsf_pkg::ST_COUNT && rippleWrap) expCnt_ff <= expCnt_ff + 9'h001;
            oscRunEn_ff <= ~sleepReq | keepOn; // [RQ3]
            settled_ff <= nxt_start == rsf_pkg::ST_READY; // [RQ2]
            readyN_ff <= nxt_start != rsf_pkg::ST_READY; // [RQ2]
        end
    end

    // ==========================================================
    // Calibration sequencer; the pump stage is optional
    always_comb begin
        nxt_cal = cal_ff;
        unique case (cal_ff)
            rsf_pkg::CAL_IDLE: if (calStart) nxt_cal = (pumpEn == 2'b00) ? rsf_pkg::CAL_REST : rsf_pkg::CAL_PUMP; // [RQ6]
            rsf_pkg::CAL_PUMP: if (pumpEnd) nxt_cal = rsf_pkg::CAL_REST;
            rsf_pkg::CAL_REST: if (calCnt_ff == `RSF_REST_CAL_CYCLES) nxt_cal = rsf_pkg::CAL_IDLE;
        endcase
    end

    // Stage counter restarts on every stage change
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cal_ff <= rsf_pkg::CAL_IDLE;
            calCnt_ff <= 8'h00;
            calBusy_ff <= 1'b0;
        end else begin
            cal_ff <= nxt_cal;
            calCnt_ff <= (nxt_cal != cal_ff || cal_ff == rsf_pkg::CAL_IDLE) ? 8'h01 : calCnt_ff + 8'h01;
            calBusy_ff <= nxt_cal != rsf_pkg::CAL_IDLE;
        end
    end

    // ==========================================================
    // Drive outputs; indices past the table select zero power
    wire [7:0] pwrPick = (pwrIdx < 3'(`RSF_TABLE_DEPTH)) ? pwrTable_ff[pwrIdx[0]] : 8'h00;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            drive_ff <= '0;
        end else begin
            drive_ff.powerSetting <= pwrPick; // [RQ4]
            drive_ff.loBufferCurrent <= frontEnd_ff[`RSF_LOBUF_MSB:`RSF_LOBUF_LSB];
            drive_ff.pumpCurrentCode <= synCal3_ff[`RSF_PCRES_MSB:`RSF_PCRES_LSB]; // [RQ7]
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign oscRunEn = oscRunEn_ff;
    assign osc_settled_flag = settled_ff;
    assign chip_ready_n = readyN_ff;
    assign calBusy = calBusy_ff;
    assign drive = drive_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    ready_pair_a: assert property (chip_ready_n == ~osc_settled_flag) // [RQ2]
        else $error("ready and settled flag disagree");
    expire_count_a: assert property ($rose(osc_settled_flag) |-> expCnt_ff == expTarget) // [RQ1]
        else $error("ready before selected expiry count");
    ripple_run_a: assert property ($rose(osc_settled_flag) |-> $past(ripple_ff) == `RSF_RIPPLE_LAST) // [RQ10]
        else $error("ready not at counter wrap");
    keep_on_a: assert property (sleepReq && keepOn |=> oscRunEn) // [RQ3]
        else $error("oscillator stopped in sleep with keep-on");
    power_pick_a: assert property (!wrEn && pwrIdx == 3'b001 |=> drive.powerSetting == $past(pwrTable_ff[1])) // [RQ4]
        else $error("power setting not from table");
    skip_pump_a: assert property (cal_ff == rsf_pkg::CAL_IDLE && calStart && pumpEn == 2'b00 // [RQ6]
        |=> cal_ff == rsf_pkg::CAL_REST)
        else $error("pump stage not skipped");
    pump_result_a: assert property (pumpEnd |=> synCal3_ff[3:0] == $past(pumpCalCode)) // [RQ7]
        else $error("pump result not stored");
    unused_zero_a: assert property (resTune_ff[2] == 1'b0 && smCfg0_ff[7:4] == 4'h0 && frontEnd_ff[7:6] == 2'b00 // [RQ9]
        && frontEnd_ff[3] == 1'b0)
        else $error("unused bit not zero");
    field_hold_a: assert property (!(wrEn && selFe) |=> $stable(frontEnd_ff)) // [RQ11]
        else $error("field changed without write");
    reset_value_a: assert property (!$past(rstn) |-> smCfg0_ff == `RSF_RST_SMCFG0 // [RQ1] [RQ9]
        && synCal3_ff == `RSF_RST_SYNCAL3 && resTune_ff == `RSF_RST_RESTUNE)
        else $error("wrong reset value");
endmodule : rsf_config_bank

// ===== rsf_regs_map.svh
// Register indices, reset values, field positions and timing counts for the start-up and front-end bank
`ifndef RSF_REGS_MAP_SVH
`define RSF_REGS_MAP_SVH
// ==========================================================
// Register indices; the byte address is four times the index
`define RSF_IDX_SMCFG0 8'h18
`define RSF_IDX_RESTUNE 8'h20
`define RSF_IDX_FRONTEND 8'h22
`define RSF_IDX_SYNCAL3 8'h23
`define RSF_IDX_PWRTABLE 8'h3E
// ==========================================================
// Reset values
`define RSF_RST_SMCFG0 8'h04
`define RSF_RST_RESTUNE 8'hF8
`define RSF_RST_FRONTEND 8'h10
`define RSF_RST_SYNCAL3 8'hA9
`define RSF_RST_PWRENTRY0 8'h00
`define RSF_RST_PWRENTRY1 8'hC0
// ==========================================================
// Writable bit masks
`define RSF_MASK_SMCFG0 8'h0F
`define RSF_MASK_RESTUNE 8'hFB
`define RSF_MASK_FRONTEND 8'h37
`define RSF_MASK_SYNCAL3 8'hFF
// ==========================================================
// Field positions
`define RSF_KEEPON_BIT 0
`define RSF_EXPSEL_LSB 2
`define RSF_EXPSEL_MSB 3
`define RSF_PWRIDX_LSB 0
`define RSF_PWRIDX_MSB 2
`define RSF_LOBUF_LSB 4
`define RSF_LOBUF_MSB 5
`define RSF_PCRES_LSB 0
`define RSF_PCRES_MSB 3
`define RSF_PCEN_LSB 4
`define RSF_PCEN_MSB 5
// ==========================================================
// Counts
`define RSF_RIPPLE_LAST 6'h3F
`define RSF_EXPIRE_0 9'h001
`define RSF_EXPIRE_1 9'h010
`define RSF_EXPIRE_2 9'h040
`define RSF_EXPIRE_3 9'h100
`define RSF_TABLE_DEPTH 2
`define RSF_PUMP_CAL_CYCLES 8'h10
`define RSF_REST_CAL_CYCLES 8'h20
`endif

// ===== rsf_pkg.sv
// Types shared by the start-up and front-end configuration bank
package rsf_pkg;
    // ==========================================================
    // Start-up sequencer states
    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_COUNT = 3'b010,
        ST_READY = 3'b100
    } rsf_start_t;
    // ==========================================================
    // Synthesizer calibration states
    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_PUMP = 3'b010,
        CAL_REST = 3'b100
    } rsf_cal_t;
    // ==========================================================
    // Front-end drive settings that travel together
    typedef struct packed {
        logic [7:0] powerSetting;
        logic [1:0] loBufferCurrent;
        logic [3:0] pumpCurrentCode;
    } rsf_drive_t;
endpackage : rsf_pkg

// ===== test_radio_startup_frontend_cfg.sv
// Register, start-up, power table and calibration tests for the start-up and front-end bank
`include "rsf_regs_map.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fails++; \
    $display("[FAIL] %0t got %0h expected %0h", $time, got, exp); end end
module test_radio_startup_frontend_cfg;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Stimulus and observed signals
    logic core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, sleepReq = 1, oscGood = 0, calStart = 0;
    logic [3:0] pumpCalCode = 4'h0;
    logic oscRunEn, osc_settled_flag, chip_ready_n, calBusy;
    rsf_pkg::rsf_drive_t drive;
    int fails = 0, comparisons = 0;
    logic [31:0] rd;
    logic er;
    rsf_config_bank u_dut (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleepReq(sleepReq), .oscGood(oscGood), .calStart(calStart), .pumpCalCode(pumpCalCode),
        .oscRunEn(oscRunEn), .osc_settled_flag(osc_settled_flag), .chip_ready_n(chip_ready_n),
        .calBusy(calBusy), .drive(drive));
    // 10 MHz clock
    always #50 core_clk = ~core_clk;
    // ==========================================================
    // Verdict and run end
    task end_sim;
        $display("Tests done: %0d comparisons, %0d mismatches", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    // Long enough for all four timeout codes, with margin
    initial begin
        #(60000 * 100);
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_sim();
    end
    // ==========================================================
    // APB master: holds the request until pready is seen at a rising edge
    task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            $display("[FAIL] %0t no pready", $time);
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task rdchk(input logic [9:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0);
        `CHK(er, 1'b0)
        `CHK(rd, exp)
    endtask : rdchk
    task wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : wait_cyc
    // Startup: counts edges from oscillator good to the settled flag
    task startup(input logic [1:0] code, input int n);
        int c;
        apb(1, 10'h060, {28'h0, code, 2'b00});
        @(posedge core_clk);
        oscGood <= 1;
        c = 0;
        while (osc_settled_flag !== 1'b1 && c < n * 64 + 20) begin
            @(posedge core_clk);
            c++;
        end
        `CHK(c >= n * 64 && c <= n * 64 + 5, 1'b1)
        `CHK(chip_ready_n, 1'b0)
        oscGood <= 0;
        wait_cyc(3);
        `CHK({osc_settled_flag, chip_ready_n}, 2'b01)
        $display("Test startup code %0d done", code);
    endtask : startup
    // Calibration pulse, bounded waits on busy; busy length shows whether the pump stage ran
    task calib(input logic [3:0] code, input int busyLen);
        int n;
        pumpCalCode <= code;
        @(posedge core_clk);
        calStart <= 1;
        @(posedge core_clk);
        calStart <= 0;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (calBusy !== 1'b0 && n < 200);
        `CHK(n < 200, 1'b1)
        `CHK(n, busyLen)
    endtask : calib
    // ==========================================================
    // Main sequence
    logic [7:0] pexp [3] = '{8'h12, 8'h34, 8'h00};
    initial begin
        wait_cyc(5);
        rstn <= 1;
        rdchk(10'h060, 32'h04);
        rdchk(10'h080, 32'hF8);
        rdchk(10'h088, 32'h10);
        rdchk(10'h08C, 32'hA9);
        rdchk(10'h0F8, {16'h0, 8'(`RSF_RST_PWRENTRY1), 8'(`RSF_RST_PWRENTRY0)});
        `CHK(drive, {8'(`RSF_RST_PWRENTRY0), 2'b01, 4'h9})
        `CHK(oscRunEn, 1'b0)
        $display("Test reset values done");
        // All ones, then zeros to the tuning register only; unused bits stay zero
        apb(1, 10'h060, 32'hFFFFFFFF);
        apb(1, 10'h080, 32'hFFFFFFFF);
        apb(1, 10'h088, 32'hFFFFFFFF);
        apb(1, 10'h08C, 32'hFFFFFFFF);
        rdchk(10'h060, 32'h0F);
        rdchk(10'h080, 32'hFB);
        rdchk(10'h088, 32'h37);
        rdchk(10'h08C, 32'hFF);
        apb(1, 10'h080, 32'h0);
        rdchk(10'h080, 32'h00);
        apb(1, 10'h004, 32'hFFFFFFFF);
        `CHK(er, 1'b1)
        apb(0, 10'h004, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0})
        rdchk(10'h060, 32'h0F);
        $display("Test access kinds done");
        // Keep-on bit during sleep
        apb(1, 10'h060, 32'h04);
        wait_cyc(2);
        `CHK(oscRunEn, 1'b0)
        apb(1, 10'h060, 32'h05);
        wait_cyc(2);
        `CHK(oscRunEn, 1'b1)
        sleepReq <= 0;
        apb(1, 10'h060, 32'h04);
        wait_cyc(2);
        `CHK(oscRunEn, 1'b1)
        $display("Test keep-on done");
        // Power table index, including an index past the table
        apb(1, 10'h0F8, 32'h3412);
        for (int i = 0; i < 3; i++) begin
            apb(1, 10'h088, 32'h20 | i);
            wait_cyc(2);
            `CHK(drive.powerSetting, pexp[i])
            `CHK(drive.loBufferCurrent, 2'b10)
        end
        // Host leaves the index at 000 for the non-keyed formats
        apb(1, 10'h088, 32'h20);
        wait_cyc(2);
        `CHK(drive.powerSetting, 8'h12)
        $display("Test power table done");
        startup(2'b00, 1);
        startup(2'b01, 16);
        startup(2'b10, 64);
        startup(2'b11, 256);
        // Pump stage on, then skipped with enable zero
        apb(1, 10'h08C, 32'hA3);
        calib(4'h5, 1 + 16 + 32);
        rdchk(10'h08C, 32'hA5);
        wait_cyc(2);
        `CHK(drive.pumpCurrentCode, 4'h5)
        apb(1, 10'h08C, 32'h83);
        calib(4'hC, 1 + 32);
        rdchk(10'h08C, 32'h83);
        $display("Test calibration done");
        end_sim();
    end
endmodule : test_radio_startup_frontend_cfg
